/* rtl/pwr_alarm_pkg.sv */
/*
 * Package: register offsets, reset values, power codes and carried structs
 * for the power-mode and alarm register bank.
 * Assumes an 8-bit register port with a 12-bit address from the device core.
 */
package pwr_alarm_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [11:0] OFS_CFG_A   = 12'h299;
  localparam logic [11:0] OFS_CFG_B   = 12'h29a;
  localparam logic [11:0] OFS_CFG_C   = 12'h29b;
  localparam logic [11:0] OFS_CFG_D   = 12'h29c;
  localparam logic [11:0] OFS_SUMMARY = 12'h2c0;
  localparam logic [11:0] OFS_FLAGS   = 12'h2c1;
  localparam logic [11:0] OFS_MASK    = 12'h2c2;

  // Power codes; cfg_a codes are parameters of the top
  localparam logic [7:0] CODE_B_LP = 8'h06;
  localparam logic [7:0] CODE_B_HP = 8'h0f;
  localparam logic [7:0] CODE_C_LP = 8'h00;
  localparam logic [7:0] CODE_C_HP = 8'h04;
  localparam logic [7:0] CODE_D_LP = 8'h14;
  localparam logic [7:0] CODE_D_HP = 8'h1b;

  // Alarm layout
  localparam int          NUM_ALARMS  = 6;
  localparam logic [5:0]  FLAGS_RST   = 6'h3f;
  localparam logic [5:0]  MASK_RST    = 6'h3f;
  localparam int          SUMMARY_BIT = 0;

  typedef enum logic [1:0] {
    CAL_STATUS_PIN_CAL   = 2'h1,
    CAL_STATUS_PIN_ALARM = 2'h2
  } cal_status_pin_sel_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] code_a;
    logic [7:0] code_b;
    logic [7:0] code_c;
    logic [7:0] code_d;
  } power_codes_t;

endpackage

/* rtl/alarm_flag_bit.sv */
/*
 * One sticky alarm flag with write-one-to-clear and mask gating.
 * Assumes the event input is already synchronous to core_clk.
 */
`timescale 1ns/100ps
module alarm_flag_bit (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Control
  input  wire logic event_in,
  input  wire logic clear,
  input  wire logic mask,
  // State
  output logic      flag_q,
  output logic      active
);

  logic flag_d;

  always_comb begin
    flag_d = flag_q;
    if (clear) begin
      flag_d = 1'b0;
    end
    // Set beats a same-cycle clear so no event is lost
    if (event_in) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_q <= 1'b1;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign active = flag_q & ~mask;

endmodule

/* rtl/power_mode_alarm_regs.sv */
/*
 * Power-mode configuration and alarm summary register bank.
 * Assumes a synchronous register port from the serial front end on core_clk,
 * alarm events synchronous to core_clk, and cal_status_sel from elsewhere.
 */
// Operation
// - Second power register: 0x06 is reduced power, 0x0f high performance, reset 0x0f.
// - Third power register: 0x00 is reduced power, 0x04 high performance, reset 0x04.
// - Fourth power register: 0x14 is reduced power, 0x1b high performance, reset 0x1b.
// - Summary bit 0 reads one when any unmasked alarm flag is set.
// - Each alarm can be removed from the summary by its mask bit.
// - The calibration-status pin carries the summary when so selected.
// - Alarm flags reset to 0x3f and clear where written with one.
// - A flag sets on its condition and holds until written with one.
// - Every alarm flag is one after reset.
// - A set mask bit keeps its flag out of the summary; masks reset to one.
`timescale 1ns/100ps
module power_mode_alarm_regs #(
  parameter logic [7:0] CODE_A_LP  = 8'h01,
  parameter logic [7:0] CODE_A_HP  = 8'h00,
  parameter logic [7:0] CODE_A_RST = 8'h00
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // Register port
  input  wire pwr_alarm_pkg::reg_req_t    req,
  output logic [7:0]                      rdata,
  output logic                            rvalid,
  // Alarm sources
  input  wire logic [5:0]                 alarm_events,
  // Mode and pin
  input  wire logic                       cal_busy,
  input  wire logic [1:0]                 cal_status_sel,
  output logic                            reduced_power,
  output pwr_alarm_pkg::power_codes_t     power_codes,
  output logic                            cal_status_pin,
  output logic                            alarm_summary
);

  ////////////////////////////////////////////////////////////////////////////
  // Power-mode registers

  logic [7:0] cfg_a_q, cfg_a_d;
  logic [7:0] cfg_b_q, cfg_b_d;
  logic [7:0] cfg_c_q, cfg_c_d;
  logic [7:0] cfg_d_q, cfg_d_d;

  // Reserved codes are stored as written; only the full set selects low power
  always_comb begin
    cfg_a_d = cfg_a_q;
    cfg_b_d = cfg_b_q;
    cfg_c_d = cfg_c_q;
    cfg_d_d = cfg_d_q;
    if (req.wr) begin
      case (req.addr)
        pwr_alarm_pkg::OFS_CFG_A: begin
          cfg_a_d = req.wdata;
        end
        pwr_alarm_pkg::OFS_CFG_B: begin
          cfg_b_d = req.wdata;
        end
        pwr_alarm_pkg::OFS_CFG_C: begin
          cfg_c_d = req.wdata;
        end
        pwr_alarm_pkg::OFS_CFG_D: begin
          cfg_d_d = req.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_a_q <= CODE_A_RST;
      cfg_b_q <= pwr_alarm_pkg::CODE_B_HP;
      cfg_c_q <= pwr_alarm_pkg::CODE_C_HP;
      cfg_d_q <= pwr_alarm_pkg::CODE_D_HP;
    end else begin
      cfg_a_q <= cfg_a_d;
      cfg_b_q <= cfg_b_d;
      cfg_c_q <= cfg_c_d;
      cfg_d_q <= cfg_d_d;
    end
  end

  logic reduced_d;
  logic reduced_q;

  // Mixed or reserved sets fall back to high performance, since the
  // four writes of a mode change land on different cycles
  always_comb begin
    reduced_d = (cfg_a_q == CODE_A_LP)
              & (cfg_b_q == pwr_alarm_pkg::CODE_B_LP)
              & (cfg_c_q == pwr_alarm_pkg::CODE_C_LP)
              & (cfg_d_q == pwr_alarm_pkg::CODE_D_LP);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reduced_q <= 1'b0;
    end else begin
      reduced_q <= reduced_d;
    end
  end

  assign reduced_power      = reduced_q;
  assign power_codes.code_a = cfg_a_q;
  assign power_codes.code_b = cfg_b_q;
  assign power_codes.code_c = cfg_c_q;
  assign power_codes.code_d = cfg_d_q;

  ////////////////////////////////////////////////////////////////////////////
  // Alarm flags and mask

  logic [5:0] mask_q, mask_d;
  logic [5:0] flags;
  logic [5:0] active;
  logic       flag_wr;

  assign flag_wr = req.wr & (req.addr == pwr_alarm_pkg::OFS_FLAGS);

  always_comb begin
    mask_d = mask_q;
    if (req.wr && (req.addr == pwr_alarm_pkg::OFS_MASK)) begin
      mask_d = req.wdata[5:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask_q <= pwr_alarm_pkg::MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  genvar i;
  generate
    for (i = 0; i < pwr_alarm_pkg::NUM_ALARMS; i++) begin : g_flag
      alarm_flag_bit u_flag (
        .core_clk (core_clk),
        .rst      (rst),
        .event_in (alarm_events[i]),
        .clear    (flag_wr & req.wdata[i]),
        .mask     (mask_q[i]),
        .flag_q   (flags[i]),
        .active   (active[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Summary, pin and read data

  logic summary;
  logic pin_d, pin_q;

  assign summary       = |active;
  assign alarm_summary = summary;

  always_comb begin
    case (cal_status_sel)
      pwr_alarm_pkg::CAL_STATUS_PIN_ALARM: begin
        pin_d = summary;
      end
      pwr_alarm_pkg::CAL_STATUS_PIN_CAL: begin
        pin_d = cal_busy;
      end
      default: begin
        pin_d = 1'b0;
      end
    endcase
  end

  logic [7:0] rdata_d, rdata_q;
  logic       rvalid_q;

  always_comb begin
    rdata_d = rdata_q;
    if (req.rd) begin
      case (req.addr)
        pwr_alarm_pkg::OFS_CFG_A: begin
          rdata_d = cfg_a_q;
        end
        pwr_alarm_pkg::OFS_CFG_B: begin
          rdata_d = cfg_b_q;
        end
        pwr_alarm_pkg::OFS_CFG_C: begin
          rdata_d = cfg_c_q;
        end
        pwr_alarm_pkg::OFS_CFG_D: begin
          rdata_d = cfg_d_q;
        end
        pwr_alarm_pkg::OFS_SUMMARY: begin
          rdata_d = 8'h00;
          rdata_d[pwr_alarm_pkg::SUMMARY_BIT] = summary;
        end
        pwr_alarm_pkg::OFS_FLAGS: begin
          rdata_d = {2'h0, flags};
        end
        pwr_alarm_pkg::OFS_MASK: begin
          rdata_d = {2'h0, mask_q};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
      pin_q    <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= req.rd;
      pin_q    <= pin_d;
    end
  end

  assign rdata          = rdata_q;
  assign rvalid         = rvalid_q;
  assign cal_status_pin = pin_q;

endmodule

/* test/pwr_alarm_checker.sv */
/* Port checker for the power-mode and alarm bank.
   Assumes it is bound onto power_mode_alarm_regs on core_clk. */
`timescale 1ns/100ps
module pwr_alarm_checker #(
  parameter logic [7:0] CODE_A_LP  = 8'h01,
  parameter logic [7:0] CODE_A_RST = 8'h00
) (
  // Watched ports
  input wire logic                        core_clk,
  input wire logic                        rst,
  input wire pwr_alarm_pkg::reg_req_t     req,
  input wire logic [7:0]                  rdata,
  input wire logic                        rvalid,
  input wire logic                        cal_busy,
  input wire logic [1:0]                  cal_status_sel,
  input wire logic                        reduced_power,
  input wire pwr_alarm_pkg::power_codes_t power_codes,
  input wire logic                        cal_status_pin,
  input wire logic                        alarm_summary
);
  localparam logic [31:0] LP  = {CODE_A_LP, pwr_alarm_pkg::CODE_B_LP,
                                 pwr_alarm_pkg::CODE_C_LP, pwr_alarm_pkg::CODE_D_LP};
  localparam logic [31:0] RST = {CODE_A_RST, pwr_alarm_pkg::CODE_B_HP,
                                 pwr_alarm_pkg::CODE_C_HP, pwr_alarm_pkg::CODE_D_HP};
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence sum_rd;
    req.rd && req.addr == pwr_alarm_pkg::OFS_SUMMARY;
  endsequence
  sequence cfg_b_wr;
    req.wr && req.addr == pwr_alarm_pkg::OFS_CFG_B;
  endsequence
  rd_answer_a: assert property (req.rd |=> rvalid)
    else $error("read not answered");
  sum_read_a: assert property (sum_rd |=> rdata == {7'h00, $past(alarm_summary)})
    else $error("summary read wrong");
  pin_alarm_a: assert property (
    cal_status_sel == pwr_alarm_pkg::CAL_STATUS_PIN_ALARM |=> cal_status_pin == $past(alarm_summary))
    else $error("pin not summary");
  pin_cal_a: assert property (
    cal_status_sel == pwr_alarm_pkg::CAL_STATUS_PIN_CAL |=> cal_status_pin == $past(cal_busy))
    else $error("pin not busy");
  lp_mode_a: assert property (reduced_power == ($past(power_codes) == LP))
    else $error("reduced power wrong");
  code_b_wr_a: assert property (cfg_b_wr |=> power_codes.code_b == $past(req.wdata))
    else $error("code b not stored");
  code_rst_a: assert property (
    $fell(rst) |-> power_codes == RST)
    else $error("power reset wrong");
  unmapped_rd_a: assert property (req.rd && req.addr == 12'h000 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind power_mode_alarm_regs pwr_alarm_checker #(.CODE_A_LP(CODE_A_LP), .CODE_A_RST(CODE_A_RST))
  u_pwr_alarm_checker (.core_clk(core_clk), .rst(rst), .req(req), .rdata(rdata),
  .rvalid(rvalid), .cal_busy(cal_busy), .cal_status_sel(cal_status_sel),
  .reduced_power(reduced_power), .power_codes(power_codes),
  .cal_status_pin(cal_status_pin), .alarm_summary(alarm_summary));

/* test/test_power_mode_alarm_regs.sv */
/* Register-level bench for the power-mode and alarm bank.
   Assumes default parameters of the bank; inputs change at falling edges. */
`timescale 1ns/100ps
module test_power_mode_alarm_regs;
  logic                        core_clk = 1'b0;
  logic                        rst = 1'b1;
  pwr_alarm_pkg::reg_req_t     req = '0;
  logic [7:0]                  rdata;
  logic                        rvalid;
  logic [5:0]                  alarm_events = 6'h00;
  logic                        cal_busy = 1'b0;
  logic [1:0]                  cal_status_sel = 2'h0;
  logic                        reduced_power;
  pwr_alarm_pkg::power_codes_t power_codes;
  logic                        cal_status_pin;
  logic                        alarm_summary;
  int                          err_count = 0;
  int                          total_checks = 0;
  always #20 core_clk = ~core_clk;
  power_mode_alarm_regs u_power_mode_alarm_regs (
    .core_clk(core_clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .alarm_events(alarm_events), .cal_busy(cal_busy), .cal_status_sel(cal_status_sel),
    .reduced_power(reduced_power), .power_codes(power_codes),
    .cal_status_pin(cal_status_pin), .alarm_summary(alarm_summary));
  //////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge core_clk);
    req.wr = 1'b0;
  endtask
  // Read answer lands one edge after the strobe
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge core_clk);
    req.rd = 1'b0;
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp);
  endtask
  task automatic pin_chk(input logic exp);
    check({7'h00, cal_status_pin}, {7'h00, exp});
  endtask
  //////////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    err_count++;
    close_out();
  end
  initial begin
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    rd_chk(pwr_alarm_pkg::OFS_CFG_B, 8'h0f);
    rd_chk(pwr_alarm_pkg::OFS_CFG_C, 8'h04);
    rd_chk(pwr_alarm_pkg::OFS_CFG_D, 8'h1b);
    rd_chk(pwr_alarm_pkg::OFS_FLAGS, 8'h3f);
    rd_chk(pwr_alarm_pkg::OFS_MASK, 8'h3f);
    rd_chk(pwr_alarm_pkg::OFS_SUMMARY, 8'h00);
    rd_chk(12'h000, 8'h00);
    wr(pwr_alarm_pkg::OFS_FLAGS, 8'h3f);
    rd_chk(pwr_alarm_pkg::OFS_FLAGS, 8'h00);
    // One-cycle event must stick until cleared
    alarm_events = 6'h20;
    @(negedge core_clk);
    alarm_events = 6'h00;
    rd_chk(pwr_alarm_pkg::OFS_FLAGS, 8'h20);
    rd_chk(pwr_alarm_pkg::OFS_SUMMARY, 8'h00);
    cal_status_sel = 2'h2;
    wr(pwr_alarm_pkg::OFS_MASK, 8'h1f);
    wr(pwr_alarm_pkg::OFS_SUMMARY, 8'h00);
    rd_chk(pwr_alarm_pkg::OFS_SUMMARY, 8'h01);
    pin_chk(1'b1);
    wr(pwr_alarm_pkg::OFS_FLAGS, 8'h20);
    rd_chk(pwr_alarm_pkg::OFS_SUMMARY, 8'h00);
    pin_chk(1'b0);
    // Event in the clearing cycle keeps its flag
    alarm_events = 6'h01;
    wr(pwr_alarm_pkg::OFS_FLAGS, 8'h01);
    alarm_events = 6'h00;
    rd_chk(pwr_alarm_pkg::OFS_FLAGS, 8'h01);
    cal_status_sel = 2'h1;
    cal_busy = 1'b1;
    @(negedge core_clk);
    pin_chk(1'b1);
    // Calibration idle before the mode change
    cal_busy = 1'b0;
    wr(pwr_alarm_pkg::OFS_CFG_A, 8'h01);
    pin_chk(1'b0);
    wr(pwr_alarm_pkg::OFS_CFG_B, pwr_alarm_pkg::CODE_B_LP);
    wr(pwr_alarm_pkg::OFS_CFG_C, pwr_alarm_pkg::CODE_C_LP);
    check({7'h00, reduced_power}, 8'h00);
    wr(pwr_alarm_pkg::OFS_CFG_D, pwr_alarm_pkg::CODE_D_LP);
    cal_busy = 1'b1;
    @(negedge core_clk);
    check({7'h00, reduced_power}, 8'h01);
    pin_chk(1'b1);
    rd_chk(pwr_alarm_pkg::OFS_CFG_B, 8'h06);
    rd_chk(pwr_alarm_pkg::OFS_CFG_C, 8'h00);
    rd_chk(pwr_alarm_pkg::OFS_CFG_D, 8'h14);
    // Reserved code falls back to high performance
    wr(pwr_alarm_pkg::OFS_CFG_D, 8'h15);
    @(negedge core_clk);
    check({7'h00, reduced_power}, 8'h00);
    rd_chk(pwr_alarm_pkg::OFS_CFG_D, 8'h15);
    // Unused selector codes hold the pin low
    cal_status_sel = 2'h3;
    @(negedge core_clk);
    pin_chk(1'b0);
    // Mid-run reset brings written state back to defaults
    rst = 1'b1;
    @(negedge core_clk);
    rst = 1'b0;
    check({7'h00, reduced_power}, 8'h00);
    rd_chk(pwr_alarm_pkg::OFS_CFG_D, 8'h1b);
    rd_chk(pwr_alarm_pkg::OFS_FLAGS, 8'h3f);
    close_out();
  end
endmodule
